// ### rtl/asp_serial_port.sv
`timescale 1ns/100ps

module asp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic in_valid, // word offered
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic in_ready, // room for a word
  input wire logic out_ready, // drain takes word
  output logic out_valid, // word available
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic rdy_q;
  wire push = in_valid && in_ready;
  wire pop = out_ready && out_valid;
  wire [AW-1:0] last = AW'(DEPTH - 1);
  wire [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  // ready taken from the next count, so the port leaves a flip-flop
  assign in_ready = rdy_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  always_ff @(posedge clk) begin
    if (push) mem[wr_q] <= in_data;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      if (push) wr_q <= (wr_q == last) ? '0 : wr_q + AW'(1);
      if (pop) rd_q <= (rd_q == last) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule : asp_fifo

module asp_serial_port import asp_pkg::*; #(
  parameter int FRAME_BITS = FRAME_BITS_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic reg_wr_en, // register write strobe
  input wire logic [6:0] reg_addr, // register address
  input wire logic [8:0] reg_wr_data, // register write data
  output logic [8:0] reg_rd_data, // read data, one cycle late
  input wire logic mclk_tick, // one pulse per master clock edge
  input wire logic pll_tick, // one pulse per PLL clock edge
  input wire logic sample_in_valid, // converted sample offered
  input wire logic [SAMPLE_W-1:0] sample_in_data, // MSB aligned
  output logic sample_in_ready, // buffer has room
  input wire logic bitclk_pin_in, // bit clock pin level
  output logic bitclk_pin_out, // bit clock drive value
  output logic bitclk_pin_oe, // bit clock driven
  input wire logic frame_sync_pin_in, // frame pin level
  output logic frame_sync_pin_out, // frame drive value
  output logic frame_sync_pin_oe, // frame driven
  output logic sample_serial_out // serial data
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [8:0] sfc_q;
  logic [8:0] cgc_q;
  logic [8:0] rd_q;
  wire sel_sfc = (reg_addr == REG_SERIAL_FORMAT);
  wire sel_cgc = (reg_addr == REG_CLOCK_GEN);
  wire [8:0] rd_d = sel_sfc ? sfc_q : (sel_cgc ? cgc_q : 9'h000);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfc_q <= SFC_RESET;
      cgc_q <= CGC_RESET;
      rd_q <= 9'h000;
    end else begin
      if (reg_wr_en && sel_sfc) sfc_q <= reg_wr_data & SFC_MASK;
      if (reg_wr_en && sel_cgc) cgc_q <= reg_wr_data & CGC_MASK;
      rd_q <= rd_d;
    end
  end

  wire swap = sfc_q[SWAP_BIT];
  wire [1:0] fmt = sfc_q[FMT_LSB+:2]; // [R9]
  wire [1:0] wl = sfc_q[WL_LSB+:2];
  wire fpol = sfc_q[FPOL_BIT];
  wire bpol = sfc_q[BPOL_BIT];
  wire ms = cgc_q[MS_BIT];
  wire [2:0] bdiv_raw = cgc_q[BDIV_LSB+:3];
  wire [2:0] scale = cgc_q[SCALE_LSB+:3];
  wire csrc = cgc_q[CSRC_BIT];
  wire dsp = (fmt == FMT_DSP);
  wire i2s = (fmt == FMT_I2S);
  wire [6:0] wlen = WL_BITS[wl]; // [R10]
  // reserved divider codes behave as the slowest legal one
  wire [2:0] bdiv = (bdiv_raw > BDIV_MAX) ? BDIV_MAX : bdiv_raw; // [R14]

  // ---------------------------------------------------------------
  // clock generation
  // ---------------------------------------------------------------
  logic [5:0] acc_q;
  logic [4:0] div_q;
  logic bclk_gen_q;
  logic frm_gen_q;
  logic [6:0] gcnt_q;
  logic bpin_q;
  logic fpin_q;
  logic oe_q;
  wire src_tick = csrc ? pll_tick : mclk_tick; // [R17]
  wire [5:0] half = {1'b0, SCALE_HALF[scale]};
  wire [5:0] acc_sum = acc_q + 6'h02;
  wire sc_tick = src_tick && (acc_sum >= half); // [R16]
  wire [5:0] acc_d = !src_tick ? acc_q :
                     (sc_tick ? acc_sum - half : acc_sum);
  wire [4:0] div_lim = 5'((6'h01 << bdiv) - 6'h01);
  wire div_hit = sc_tick && (div_q == div_lim); // [R14]
  wire [4:0] div_d = !sc_tick ? div_q : (div_hit ? 5'h00 : div_q + 5'h01);
  wire gen_fall = div_hit && bclk_gen_q;
  wire [6:0] glast = 7'(FRAME_BITS - 1);
  wire [6:0] ghalf = 7'(FRAME_BITS / 2);
  // frame length is whole bit clocks, so no short pulse is produced
  wire [6:0] gcnt_d = !gen_fall ? gcnt_q :
                      ((gcnt_q == glast) ? 7'h00 : gcnt_q + 7'h01); // [R15]
  wire frm_gen_d = dsp ? (gcnt_d == 7'h00) :
                   (i2s ? (gcnt_d >= ghalf) : (gcnt_d < ghalf));
  wire bclk_gen_d = (ms && div_hit) ? !bclk_gen_q : bclk_gen_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= 6'h00;
      div_q <= 5'h00;
      bclk_gen_q <= 1'b0;
      frm_gen_q <= 1'b0;
      gcnt_q <= 7'h00;
    end else begin
      acc_q <= acc_d;
      div_q <= div_d;
      bclk_gen_q <= bclk_gen_d;
      gcnt_q <= gcnt_d;
      frm_gen_q <= frm_gen_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bpin_q <= 1'b0;
      fpin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      bpin_q <= bclk_gen_d ^ bpol; // [R12]
      fpin_q <= frm_gen_d ^ (fpol && !dsp); // [R11]
      oe_q <= ms; // [R13] [R19]
    end
  end

  // ---------------------------------------------------------------
  // slave pin capture
  // ---------------------------------------------------------------
  logic [1:0] bsync_q;
  logic [1:0] fsync_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bsync_q <= 2'b00;
      fsync_q <= 2'b00;
    end else begin
      bsync_q <= {bsync_q[0], bitclk_pin_in};
      fsync_q <= {fsync_q[0], frame_sync_pin_in};
    end
  end

  // ---------------------------------------------------------------
  // serialiser
  // ---------------------------------------------------------------
  logic bprev_q;
  logic fprev_q;
  logic [6:0] pos_q;
  logic [6:0] len_q;
  logic [SAMPLE_W-1:0] shift_q;
  logic dout_q;
  logic fifo_valid;
  logic [SAMPLE_W-1:0] fifo_data;
  // DSP pulse width is free; only its rising edge starts a frame
  wire bclk_i = ms ? bclk_gen_q : (bsync_q[1] ^ bpol); // [R12] [R19]
  wire frm_i = ms ? frm_gen_q :
               (fsync_q[1] ^ (fpol && !dsp)); // [R11] [R7]
  wire fall_ev = bprev_q && !bclk_i; // [R20]
  wire new_frm = dsp ? (frm_i && !fprev_q) : (frm_i != fprev_q);
  wire [6:0] pos_d = new_frm ? 7'h00 :
                     ((pos_q == 7'h7f) ? pos_q : pos_q + 7'h01);
  wire left = i2s ? !frm_i : frm_i;
  wire act = swap ? !left : left; // [R8]
  wire load = fall_ev && new_frm && (dsp || left);
  wire [SAMPLE_W-1:0] word = !load ? shift_q :
                             (fifo_valid ? fifo_data : '0);
  wire [6:0] rj_start = (len_q >= wlen) ? len_q - wlen : 7'h00; // [R2]
  wire [6:0] dsp_start = (fpol ? 7'h00 : 7'h01) +
                         (swap ? wlen : 7'h00); // [R5] [R6] [R8]
  wire [6:0] start = (fmt == FMT_LJ) ? 7'h00 : // [R1]
                     (i2s ? 7'h01 : // [R3]
                     (dsp ? dsp_start : rj_start));
  wire [7:0] stop = {1'b0, start} + {1'b0, wlen};
  // everything outside the slot is idle and drives low
  wire in_slot = (dsp || act) && (pos_d >= start) &&
                 ({1'b0, pos_d} < stop); // [R4] [R21]
  wire [4:0] k = 5'(pos_d - start);
  wire bit_d = in_slot && word[5'h1f - k]; // [R18]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bprev_q <= 1'b0;
      fprev_q <= 1'b0;
      pos_q <= 7'h00;
      len_q <= 7'h00;
      shift_q <= '0;
      dout_q <= 1'b0;
    end else begin
      bprev_q <= bclk_i;
      if (fall_ev) begin
        fprev_q <= frm_i;
        pos_q <= pos_d;
        if (new_frm) len_q <= pos_q + 7'h01;
        shift_q <= word;
        dout_q <= bit_d; // [R20]
      end
    end
  end

  asp_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(sample_in_valid),
    .in_data(sample_in_data),
    .in_ready(sample_in_ready),
    .out_ready(load),
    .out_valid(fifo_valid),
    .out_data(fifo_data)
  );

  assign reg_rd_data = rd_q;
  assign bitclk_pin_out = bpin_q;
  assign frame_sync_pin_out = fpin_q;
  assign bitclk_pin_oe = oe_q;
  assign frame_sync_pin_oe = oe_q;
  assign sample_serial_out = dout_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_SLAVE_UNDRIVEN: assert property ( // [R19]
    !ms ##1 !ms |-> !bitclk_pin_oe && !frame_sync_pin_oe)
    else $error("slave mode drives clock pins");
  AST_MASTER_DRIVES: assert property ( // [R13]
    ms ##1 ms |-> bitclk_pin_oe && frame_sync_pin_oe)
    else $error("master mode leaves clock pins undriven");
  AST_FMT_DEFAULT: assert property ( // [R9]
    $fell(sys_rst) |-> fmt == FMT_I2S && wl == 2'b10 && !ms)
    else $error("format defaults wrong after reset");
  AST_LJ_MSB: assert property ( // [R1]
    fall_ev && fmt == FMT_LJ && new_frm && act |=>
    sample_serial_out == $past(word[31]))
    else $error("left justified MSB not on first edge");
  AST_I2S_DELAY: assert property ( // [R3]
    fall_ev && i2s && new_frm |=> !sample_serial_out)
    else $error("I2S first bit after frame not idle");
  AST_IDLE_LOW: assert property ( // [R21]
    fall_ev && !in_slot |=> !sample_serial_out)
    else $error("idle slot not driven low");
  AST_DATA_ON_FALL: assert property ( // [R20]
    $changed(sample_serial_out) |-> $past(fall_ev))
    else $error("data changed away from falling edge");
  AST_DIV_STEP: assert property ( // [R14]
    $changed(bclk_gen_q) |-> $past(div_hit) && $past(ms))
    else $error("bit clock toggled without divider tick");
  AST_BCLK_POL: assert property ( // [R12]
    1'b1 |=> bitclk_pin_out == (bclk_gen_q ^ $past(bpol)))
    else $error("bit clock pin polarity wrong");
  AST_SCALE_SRC: assert property ( // [R16] [R17]
    sc_tick |-> (csrc ? pll_tick : mclk_tick))
    else $error("scaled tick without source tick");
  AST_DSP_MODE_B: assert property ( // [R5]
    fall_ev && dsp && new_frm && fpol && !swap |-> in_slot && k == 5'h00)
    else $error("DSP mode B MSB not on first edge");
endmodule : asp_serial_port

// ### rtl/asp_pkg.sv
// Function
// R1: left-justified MSB on first edge after frame
// R2: right-justified LSB on last edge before frame
// R3: I2S MSB on second edge after frame
// R4: idle bit clocks tolerated per format
// R5: DSP MSB on edge one or two
// R6: DSP right data follows left without gap
// R7: host DSP pulse shorter than sample period
// R8: phase swap moves data to right phase
// R9: format field selects RJ, LJ, I2S, DSP
// R10: word length field selects 16/20/24/32 bits
// R11: frame polarity inverts frame outside DSP
// R12: bit clock polarity inverts bit clock sense
// R13: master select drives bit clock and frame
// R14: bit clock divider 1 to 32
// R15: short bit clock pulse at frame end allowed
// R16: clock scaler divides source 1 to 12
// R17: clock source picks master clock or PLL
// R18: every format sends MSB first
// R19: slave follows host clocks, pins undriven
// R20: data changes on falling bit clock edge
// R21: unused bit slots drive data low
package asp_pkg;
  localparam logic [6:0] REG_SERIAL_FORMAT = 7'h04;
  localparam logic [6:0] REG_CLOCK_GEN = 7'h06;
  localparam logic [8:0] SFC_RESET = 9'h050;
  localparam logic [8:0] CGC_RESET = 9'h140;
  localparam logic [8:0] SFC_MASK = 9'h1fa;
  localparam logic [8:0] CGC_MASK = 9'h1fd;
  localparam int SWAP_BIT = 1;
  localparam int FMT_LSB = 3;
  localparam int WL_LSB = 5;
  localparam int FPOL_BIT = 7;
  localparam int BPOL_BIT = 8;
  localparam int MS_BIT = 0;
  localparam int BDIV_LSB = 2;
  localparam int SCALE_LSB = 5;
  localparam int CSRC_BIT = 8;
  localparam logic [2:0] BDIV_MAX = 3'h5;
  localparam int FRAME_BITS_DEF = 64;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int SAMPLE_W = 32;
  // scaler ratios held in half steps so that 1.5 stays exact
  localparam logic [4:0] SCALE_HALF [8] =
    '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
  localparam logic [6:0] WL_BITS [4] = '{7'h10, 7'h14, 7'h18, 7'h20};
  typedef enum logic [1:0] {
    FMT_RJ = 2'b00,
    FMT_LJ = 2'b01,
    FMT_I2S = 2'b10,
    FMT_DSP = 2'b11
  } asp_fmt_type;
endpackage : asp_pkg

// ### testbench/asp_host.sv
`timescale 1ns/100ps
// ----------
// host port
// ----------
module asp_host #(
  parameter int HALF = 8,
  parameter int PHASE = 34
) (
  input wire logic clk, // system clock
  input wire logic run, // clocks running
  input wire logic dsp, // pulse framing
  input wire logic bclk, // resolved bit clock
  input wire logic frame, // resolved frame
  input wire logic sdata, // device data
  output logic bclk_drv, // bit clock drive
  output logic frame_drv // frame drive
);
  int tc = 0, bc = 0;
  logic bq = 1'h0, fq = 1'h0;
  logic [7:0] n = 8'h00;
  logic [127:0] sh = '0;
  logic [136:0] rec_q [$];
  initial bclk_drv = 1'h0;
  initial frame_drv = 1'h0;
  // frame moves just after rising, clear of the falling sample point
  always @(posedge clk) if (run) begin
    tc = tc + 1;
    if (tc == HALF) begin
      tc = 0;
      bclk_drv <= !bclk_drv;
      if (!bclk_drv) bc = (bc + 1) % (2 * PHASE);
    end
    if (tc == 2 && bclk_drv) frame_drv <= dsp ? bc == 0 : bc < PHASE;
  end
  // idle slots are kept as zeros, so gaps show up in the record
  always @(posedge clk) begin
    if (bclk && !bq) begin
      if (frame != fq && (!dsp || frame)) begin
        rec_q.push_back({fq, n, sh});
        sh = '0;
        n = 8'h00;
      end
      fq = frame;
      sh = {sh[126:0], sdata};
      n = n + 8'h01;
    end
    bq = bclk;
  end
endmodule : asp_host

// ### testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import asp_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, reg_wr_en = 1'h0, run = 1'h0;
  logic mclk_tick = 1'h0, pll_tick = 1'h0, sample_in_valid = 1'h0;
  logic dsp = 1'h0, bpol = 1'h0;
  logic [6:0] reg_addr = 7'h00;
  logic [8:0] reg_wr_data = 9'h000;
  logic [8:0] reg_rd_data;
  logic [31:0] sample_in_data = 32'h0000_0000;
  logic sample_in_ready, bck_out, bck_oe, frm_out, frm_oe, sdo;
  logic bck_drv, frm_drv;
  wire bck_w = bck_oe ? bck_out : bck_drv;
  wire frm_w = frm_oe ? frm_out : frm_drv;
  int err_total = 0, cmp_count = 0, cyc = 0;
  logic [31:0] sq [$];
  // master, format, word length, frame polarity, swap
  logic [6:0] cases [12] = '{7'h10, 7'h1d, 7'h28, 7'h26, 7'h00, 7'h0f,
    7'h38, 7'h33, 7'h3d, 7'h58, 7'h61, 7'h7e};
  // source, scale, divider, half period in clk
  logic [23:0] divs [8] = '{24'h10_0008, 24'h10_2020, 24'h12_1020,
    24'h03_1024, 24'h00_50c0, 24'h10_6100, 24'h11_1018, 24'h07_0048};

  asp_serial_port #(.FRAME_BITS(64), .FIFO_DEPTH(8)) u_dut (
    .clk, .sys_rst, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data,
    .mclk_tick, .pll_tick, .sample_in_valid, .sample_in_data,
    .sample_in_ready, .bitclk_pin_in(bck_w), .bitclk_pin_out(bck_out),
    .bitclk_pin_oe(bck_oe), .frame_sync_pin_in(frm_w),
    .frame_sync_pin_out(frm_out), .frame_sync_pin_oe(frm_oe),
    .sample_serial_out(sdo));
  // host samples on the internal sense of the bit clock
  asp_host u_host (.clk, .run, .dsp, .bclk(bck_w ^ bpol), .frame(frm_w),
    .sdata(sdo), .bclk_drv(bck_drv), .frame_drv(frm_drv));

  always #2.5 clk = ~clk;
  // unequal tick rates make the source select visible
  always @(posedge clk) begin
    cyc++;
    #1 mclk_tick = cyc % 6 == 0;
    pll_tick = cyc % 8 == 0;
  end

  task check(input string nm, input logic [127:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task final_report;
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  task wr(input logic [6:0] a, input logic [8:0] d);
    reg_wr_en = 1'h1;
    reg_addr = a;
    reg_wr_data = d;
    tk(1);
    reg_wr_en = 1'h0;
    tk(1);
  endtask : wr
  task rd(input logic [6:0] a, input logic [8:0] e);
    reg_addr = a;
    tk(1);
    check("reg_rd_data", reg_rd_data, e);
  endtask : rd
  task push(input logic [31:0] d);
    sample_in_data = d;
    sample_in_valid = 1'h1;
    for (int t = 0; t < 20 && sample_in_ready !== 1'h1; t++) tk(1);
    tk(1);
  endtask : push
  task toggle(output int n);
    logic v;
    v = bck_out;
    for (n = 0; n < 600 && bck_out === v; n++) tk(1);
  endtask : toggle
  // words must appear in order in full data-side phases; other such phases must be zero
  task automatic score(input int f, w, s, dl, plen);
    int j = 0, stray = 0;
    logic [136:0] r;
    logic [127:0] e;
    while (u_host.rec_q.size() > 0) begin
      r = u_host.rec_q.pop_front();
      if (r[135:128] == plen && (f == 3 || r[136] == dl)) begin
        e = '0;
        if (f == 0) s = plen - w;
        for (int k = 0; k < w && j < sq.size(); k++)
          e[plen-1-s-k] = sq[j][31-k];
        if (j < sq.size() && r[127:0] === e) j++;
        else if (r[127:0] !== '0) stray++;
      end
    end
    check("words", j, sq.size());
    check("stray", stray, 0);
  endtask : score

  initial begin
    logic [6:0] c;
    logic [23:0] d;
    int w, s, n, plen;
    void'($urandom(32'h88ba));
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'h0;
    rd(REG_SERIAL_FORMAT, SFC_RESET);
    rd(REG_CLOCK_GEN, CGC_RESET);
    wr(REG_SERIAL_FORMAT, 9'h1ff);
    rd(REG_SERIAL_FORMAT, SFC_MASK);
    wr(7'h05, 9'h1ff);
    rd(7'h05, 9'h000);
    wr(REG_CLOCK_GEN, 9'h1ff);
    rd(REG_CLOCK_GEN, CGC_MASK);
    wr(REG_CLOCK_GEN, CGC_RESET);
    wr(REG_SERIAL_FORMAT, SFC_RESET);
    // host clocks still: nothing drains, so the buffer must fill
    for (int i = 0; i < 8; i++) begin
      sq.push_back($urandom);
      push(sq[i]);
    end
    check("sample_in_ready", sample_in_ready, 1'h0);
    push($urandom);
    sample_in_valid = 1'h0;
    run = 1'h1;
    tk(11000);
    check("sample_in_ready", sample_in_ready, 1'h1);
    score(2, 24, 1, 0, 34);
    for (int i = 0; i < 12; i++) begin
      c = cases[i];
      w = WL_BITS[c[3:2]];
      dsp = c[5:4] == 2'h3;
      plen = (c[6] ? 32 : 34) * (dsp ? 2 : 1);
      s = dsp ? !c[1] + (c[0] ? w : 0) : c[5:4] == 2'h2;
      bpol = c[6] && !c[0];
      wr(REG_CLOCK_GEN, {8'h80, c[6]});
      wr(REG_SERIAL_FORMAT, {bpol, c[1], c[3:2], c[5:4], 1'h0, c[0], 1'h0});
      tk(1500);
      u_host.rec_q.delete();
      sq = {$urandom | 32'h8000_0000 | (32'h1 << (32 - w))};
      push(sq[0]);
      sample_in_valid = 1'h0;
      tk(3300);
      check("pin_oe", {bck_oe, frm_oe}, {2{c[6]}});
      score(c[5:4], w, s, (c[5:4] != 2'h2) ^ c[1] ^ c[0], plen);
    end
    for (int i = 0; i < 8; i++) begin
      d = divs[i];
      wr(REG_CLOCK_GEN, {d[20], d[18:16], d[14:12], 2'h1});
      repeat (3) toggle(n);
      check("bitclk_half", n, d[11:0]);
    end
    final_report();
  end
  initial begin
    #475000;
    err_total++;
    final_report();
  end
endmodule : testbench
